// ==== testbench/test_avts_slot_timer.sv ====
/*
  self-checking bench for the time base and slot timer: apb register access,
  queue mapping, length checks, report requests, time base and slot counting.
  assumes the package and the slot timer sources are compiled first.
*/
`timescale 1ns/1ps
module test_avts_slot_timer;
  // ==========================================================================
  // stimulus and observed signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ingress_frame_valid = 1'b0;
  logic ingress_tagged = 1'b0;
  logic [2:0] ingress_priority_code = 3'h0;
  logic [13:0] ingress_frame_len = 14'h0;
  logic ingress_sync_rx = 1'b0;
  logic egress_sync_tx = 1'b0;
  logic [13:0] egress_frame_len = 14'h0;
  logic [31:0] prdata, ingress_timestamp, egress_timestamp, time_base;
  logic pready, pslverr, to_queue4, to_queue5, ingress_len_ok, egress_gate_open;
  logic report_frame_req, slot_pulse, macro_slot_pulse;
  logic [4:0] slot_index;
  int cyc = 0;
  int errors = 0;
  int total_checks = 0;

  avts_slot_timer avts_slot_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ingress_frame_valid(ingress_frame_valid), .ingress_tagged(ingress_tagged),
    .ingress_priority_code(ingress_priority_code), .ingress_frame_len(ingress_frame_len),
    .ingress_sync_rx(ingress_sync_rx), .to_queue4(to_queue4), .to_queue5(to_queue5),
    .ingress_len_ok(ingress_len_ok), .ingress_timestamp(ingress_timestamp), .egress_sync_tx(egress_sync_tx),
    .egress_frame_len(egress_frame_len), .egress_gate_open(egress_gate_open),
    .egress_timestamp(egress_timestamp), .report_frame_req(report_frame_req), .time_base(time_base),
    .slot_index(slot_index), .slot_pulse(slot_pulse), .macro_slot_pulse(macro_slot_pulse));

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // ==========================================================================
  // reporting
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_up(input string what);
    errors++;
    $display("wrong value %s expected completion seen timeout", what);
    tally_and_finish();
  endtask : give_up

  // ==========================================================================
  // apb master: request held until pready is sampled high
  task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 16) give_up("pready");
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_xfer(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb_xfer(a, 1'b0, 32'h0, r, e);
    check(what, r, exp);
    check("slave error", {31'h0, e}, 32'h0);
  endtask : rd_check

  // ==========================================================================
  // frame and timing helpers
  task automatic sync_event(input logic exp_req);
    @(posedge pclk);
    egress_sync_tx <= 1'b1;
    ingress_sync_rx <= 1'b1;
    @(posedge pclk);
    egress_sync_tx <= 1'b0;
    ingress_sync_rx <= 1'b0;
    @(posedge pclk);
    check("report request", {31'h0, report_frame_req}, {31'h0, exp_req});
    check("egress stamp", egress_timestamp, time_base);
    check("ingress stamp", ingress_timestamp, time_base);
    @(posedge pclk);
    check("report request end", {31'h0, report_frame_req}, 32'h0);
  endtask : sync_event

  task automatic len_case(input logic [13:0] len, input logic exp);
    @(posedge pclk);
    ingress_frame_valid <= 1'b1;
    ingress_frame_len <= len;
    egress_frame_len <= len;
    repeat (2) @(posedge pclk);
    check("ingress length ok", {31'h0, ingress_len_ok}, {31'h0, exp});
    check("egress gate", {31'h0, egress_gate_open}, {31'h0, exp});
  endtask : len_case

  task automatic wait_change(output logic [31:0] v);
    logic [31:0] prev;
    int n;
    prev = time_base;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) give_up("time base");
    end while (time_base === prev);
    v = time_base;
  endtask : wait_change

  task automatic wait_pulse;
    int n;
    n = 0;
    @(posedge pclk);
    while (slot_pulse !== 1'b1) begin
      n++;
      if (n > 30000) give_up("slot pulse");
      @(posedge pclk);
    end
  endtask : wait_pulse

  // ==========================================================================
  // main sequence
  logic [31:0] r, t0;
  logic e;
  logic [1:0] msel [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  logic [4:0] mslot [5] = '{5'd7, 5'd7, 5'd15, 5'd15, 5'd31};
  logic mexp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [31:0] radj [3] = '{32'h101, 32'h102, 32'h0};
  int rlen [3] = '{25008, 24992, 25000};
  int c0;

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // time and tick counter first, before the first tick can move them
    rd_check(8'h40, 32'h0, "time counter");
    rd_check(8'h60, 32'h0, "slot and tick");
    rd_check(8'h08, 32'h0, "report control");
    rd_check(8'h0c, 32'h25, "priority map");
    rd_check(8'h10, 32'h5ee, "max length");
    rd_check(8'h50, 32'h28, "step adjust");
    rd_check(8'h70, 32'h0, "rollover adjust");
    apb_xfer(8'h24, 1'b0, 32'h0, r, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", r, 32'h0);
    wr(8'h40, 32'hffffffff);
    apb_xfer(8'h40, 1'b0, 32'h0, r, e);
    check("time not writable", {31'h0, r < 32'h1000}, 32'h1);
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        wr(8'h0c, 32'hd6);
        rd_check(8'h0c, 32'h16, "priority map");
      end
      for (int c = 0; c < 9; c++) begin
        @(posedge pclk);
        ingress_frame_valid <= 1'b1;
        ingress_tagged <= (c < 8);
        ingress_priority_code <= (c < 8) ? 3'(c) : ((p == 1) ? 3'h6 : 3'h5);
        repeat (2) @(posedge pclk);
        check("queue 4", {31'h0, to_queue4}, {31'h0, c == ((p == 1) ? 2 : 4)});
        check("queue 5", {31'h0, to_queue5}, {31'h0, c == ((p == 1) ? 6 : 5)});
      end
    end
    ingress_tagged <= 1'b0;
    len_case(14'd1518, 1'b1);
    len_case(14'd1519, 1'b0);
    wr(8'h10, 32'hf064);
    rd_check(8'h10, 32'h64, "max length");
    len_case(14'd100, 1'b1);
    len_case(14'd101, 1'b0);
    sync_event(1'b0);
    wr(8'h08, 32'hff);
    rd_check(8'h08, 32'h1, "report control");
    sync_event(1'b1);
    // step 41 for three ticks, then nominal forty again
    wait_change(t0);
    wr(8'h50, 32'hfffff329);
    for (int k = 0; k < 10; k++) wait_change(r);
    check("time after adjust", r, t0 + 32'd403);
    rd_check(8'h50, 32'h28, "step expired");
    for (int i = 0; i < 5; i++) begin
      wr(8'h70, {14'h0, msel[i], 16'h0});
      wr(8'h60, {4'h0, 12'hc30, 11'h0, mslot[i]});
      wait_pulse();
      check("macro pulse", {31'h0, macro_slot_pulse}, {31'h0, mexp[i]});
      @(posedge pclk);
      check("slot index", {27'h0, slot_index}, {27'h0, mslot[i] + 5'd1});
    end
    wr(8'h60, 32'h0c300000);
    wait_pulse();
    c0 = cyc;
    for (int i = 0; i < 3; i++) begin
      if (i < 2) wr(8'h70, radj[i]);
      wait_pulse();
      check("slot length", 32'(cyc - c0), 32'(rlen[i]));
      c0 = cyc;
    end
    rd_check(8'h70, 32'h0, "rollover expired");
    tally_and_finish();
  end
endmodule : test_avts_slot_timer

// ==== verilog/avts_pkg.sv ====
/*
  constants shared by the time base and slot timer: register indices, field
  layout, reset values and timing counts.
  assumes a 200 MHz bus clock and a 25 MHz time-base tick derived from it.
*/
package avts_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 40;
  localparam int TICK_DIV = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLOT_PERIOD_US = 125;
  localparam int MACRO_1MS_US = 1000;
  localparam int MACRO_2MS_US = 2000;
  localparam int MACRO_4MS_US = 4000;
  localparam int ROLL_NOM_INT = SLOT_PERIOD_US * 1000 / TICK_PERIOD_NS;
  localparam logic [11:0] ROLL_NOMINAL = 12'(ROLL_NOM_INT);
  localparam logic [11:0] ROLL_LONG = 12'(ROLL_NOM_INT + 1);
  localparam logic [11:0] ROLL_SHORT = 12'(ROLL_NOM_INT - 1);
  localparam logic [5:0] MACRO_SLOTS_1MS = 6'(MACRO_1MS_US / SLOT_PERIOD_US);
  localparam logic [5:0] MACRO_SLOTS_2MS = 6'(MACRO_2MS_US / SLOT_PERIOD_US);
  localparam logic [5:0] MACRO_SLOTS_4MS = 6'(MACRO_4MS_US / SLOT_PERIOD_US);

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_REPORT_CTRL = 6'h02;
  localparam logic [5:0] IDX_PRIO_MAP = 6'h03;
  localparam logic [5:0] IDX_MAX_LEN = 6'h04;
  localparam logic [5:0] IDX_TIME_COUNTER = 6'h10;
  localparam logic [5:0] IDX_STEP_ADJUST = 6'h14;
  localparam logic [5:0] IDX_SLOT_TICK = 6'h18;
  localparam logic [5:0] IDX_ROLL_ADJUST = 6'h1c;

  // ==========================================================================
  // field layout
  localparam int REPORT_EN_BIT = 0;
  localparam int CLASS_A_LSB = 0;
  localparam int CLASS_B_LSB = 3;
  localparam int PRIO_W = 3;
  localparam int MAX_LEN_LSB = 0;
  localparam int MAX_LEN_W = 12;
  localparam int STEP_LSB = 0;
  localparam int STEP_W = 6;
  localparam int STEP_PERIOD_LSB = 8;
  localparam int PERIOD_W = 4;
  localparam int SLOT_IDX_LSB = 0;
  localparam int SLOT_IDX_W = 5;
  localparam int TICK_CNT_LSB = 16;
  localparam int TICK_CNT_W = 12;
  localparam int ROLL_SEL_LSB = 0;
  localparam int SLOT_PERIOD_LSB = 8;
  localparam int MACRO_SEL_LSB = 16;
  localparam int SEL_W = 2;

  // ==========================================================================
  // reset values and selector codes
  localparam logic [2:0] CLASS_B_RST = 3'h4;
  localparam logic [2:0] CLASS_A_RST = 3'h5;
  localparam logic [11:0] MAX_LEN_RST = 12'h5ee;
  localparam logic [5:0] STEP_NOMINAL = 6'h28;
  localparam logic [1:0] ROLL_SEL_NOM = 2'h0;
  localparam logic [1:0] ROLL_SEL_LONG = 2'h1;
  localparam logic [1:0] ROLL_SEL_SHORT = 2'h2;
  localparam logic [1:0] MACRO_SEL_1MS = 2'h0;
  localparam logic [1:0] MACRO_SEL_2MS = 2'h1;
  localparam logic [1:0] MACRO_SEL_4MS = 2'h2;

endpackage : avts_pkg

// ==== verilog/avts_slot_timer.sv ====
/*
  time base, sub-slot and slot counters, priority-code queue mapping, frame
  length checks and timestamp report request, with an apb register slave.
  assumes frame-event inputs come from switch logic on pclk, so no synchroniser.
*/
// Implementation choice: the APB register port.
// How it works
// - report request per egress sync frame when enabled
// - class b code match sends to queue 4
// - class a code match sends to queue 5
// - ingress length check against maximum frame length
// - egress shaping gate uses same maximum length
// - 32-bit read-only time counter, resets to zero
// - sync frames stamped with time counter value
// - each tick adds step, nominal forty
// - adjusted step held for programmed tick count
// - sub-slot counter rolls, slot index advances
// - macro slot of 1, 2 or 4 ms
// - class 5 slot 125 us at nominal rollover, 40 ns longer or shorter under alternate rollover
// - alternate rollover held for programmed slot count
// - rollover select 3125, 3126 or 3124
`timescale 1ns/1ps
module avts_slot_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ingress frame classification
  input wire logic ingress_frame_valid,
  input wire logic ingress_tagged,
  input wire logic [2:0] ingress_priority_code,
  input wire logic [13:0] ingress_frame_len,
  input wire logic ingress_sync_rx,
  output logic to_queue4,
  output logic to_queue5,
  output logic ingress_len_ok,
  output logic [31:0] ingress_timestamp,
  // egress side
  input wire logic egress_sync_tx,
  input wire logic [13:0] egress_frame_len,
  output logic egress_gate_open,
  output logic [31:0] egress_timestamp,
  output logic report_frame_req,
  // time base and slots
  output logic [31:0] time_base,
  output logic [4:0] slot_index,
  output logic slot_pulse,
  output logic macro_slot_pulse
);

  // ==========================================================================
  // tick enable
  logic tick_en;

  avts_tick_div avts_tick_div_inst (
    .pclk(pclk),
    .presetn(presetn),
    .tick_en(tick_en)
  );

  // ==========================================================================
  // apb decode
  logic [5:0] idx;
  logic setup;
  logic wr_go;
  logic hit;
  logic [31:0] rd_data;

  logic report_en_reg;
  logic [2:0] class_b_reg;
  logic [2:0] class_a_reg;
  logic [11:0] max_len_reg;
  logic [31:0] time_base_reg;
  logic [5:0] step_reg;
  logic [3:0] step_left_reg;
  logic [11:0] tick_cnt_reg;
  logic [4:0] slot_idx_reg;
  logic [1:0] roll_sel_reg;
  logic [3:0] slot_left_reg;
  logic [1:0] macro_sel_reg;

  assign idx = paddr[7:2];
  assign setup = psel && !penable;
  assign wr_go = psel && penable && pready && pwrite && hit;

  always_comb begin
    hit = 1'b1;
    rd_data = 32'h0;
    if (idx == avts_pkg::IDX_REPORT_CTRL) begin
      rd_data[avts_pkg::REPORT_EN_BIT] = report_en_reg;
    end else if (idx == avts_pkg::IDX_PRIO_MAP) begin
      rd_data[avts_pkg::CLASS_B_LSB +: avts_pkg::PRIO_W] = class_b_reg;
      rd_data[avts_pkg::CLASS_A_LSB +: avts_pkg::PRIO_W] = class_a_reg;
    end else if (idx == avts_pkg::IDX_MAX_LEN) begin
      rd_data[avts_pkg::MAX_LEN_LSB +: avts_pkg::MAX_LEN_W] = max_len_reg;
    end else if (idx == avts_pkg::IDX_TIME_COUNTER) begin
      rd_data = time_base_reg;
    end else if (idx == avts_pkg::IDX_STEP_ADJUST) begin
      rd_data[avts_pkg::STEP_LSB +: avts_pkg::STEP_W] = step_reg;
      rd_data[avts_pkg::STEP_PERIOD_LSB +: avts_pkg::PERIOD_W] = step_left_reg;
    end else if (idx == avts_pkg::IDX_SLOT_TICK) begin
      rd_data[avts_pkg::TICK_CNT_LSB +: avts_pkg::TICK_CNT_W] = tick_cnt_reg;
      rd_data[avts_pkg::SLOT_IDX_LSB +: avts_pkg::SLOT_IDX_W] = slot_idx_reg;
    end else if (idx == avts_pkg::IDX_ROLL_ADJUST) begin
      rd_data[avts_pkg::MACRO_SEL_LSB +: avts_pkg::SEL_W] = macro_sel_reg;
      rd_data[avts_pkg::SLOT_PERIOD_LSB +: avts_pkg::PERIOD_W] = slot_left_reg;
      rd_data[avts_pkg::ROLL_SEL_LSB +: avts_pkg::SEL_W] = roll_sel_reg;
    end else begin
      hit = 1'b0;
    end
  end

  // answer is prepared in the setup cycle so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rd_data : 32'h0;
      pslverr <= setup && !hit;
    end
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      report_en_reg <= 1'b0;
      class_b_reg <= avts_pkg::CLASS_B_RST;
      class_a_reg <= avts_pkg::CLASS_A_RST;
      max_len_reg <= avts_pkg::MAX_LEN_RST;
    end else if (wr_go) begin
      if (idx == avts_pkg::IDX_REPORT_CTRL) begin
        report_en_reg <= pwdata[avts_pkg::REPORT_EN_BIT];
      end else if (idx == avts_pkg::IDX_PRIO_MAP) begin
        class_b_reg <= pwdata[avts_pkg::CLASS_B_LSB +: avts_pkg::PRIO_W];
        class_a_reg <= pwdata[avts_pkg::CLASS_A_LSB +: avts_pkg::PRIO_W];
      end else if (idx == avts_pkg::IDX_MAX_LEN) begin
        max_len_reg <= pwdata[avts_pkg::MAX_LEN_LSB +: avts_pkg::MAX_LEN_W];
      end
    end
  end

  // ==========================================================================
  // time base and step adjustment
  logic [5:0] eff_step;

  // a step other than nominal is applied only while ticks remain
  assign eff_step = (step_left_reg != 4'h0) ? step_reg : avts_pkg::STEP_NOMINAL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_base_reg <= 32'h0;
    end else if (tick_en) begin
      time_base_reg <= time_base_reg + {26'h0, eff_step};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_reg <= avts_pkg::STEP_NOMINAL;
      step_left_reg <= 4'h0;
    end else if (wr_go && idx == avts_pkg::IDX_STEP_ADJUST) begin
      step_reg <= pwdata[avts_pkg::STEP_LSB +: avts_pkg::STEP_W];
      step_left_reg <= pwdata[avts_pkg::STEP_PERIOD_LSB +: avts_pkg::PERIOD_W];
    end else if (tick_en) begin
      if (step_left_reg > 4'h1) begin
        step_left_reg <= step_left_reg - 4'h1;
      end else begin
        step_left_reg <= 4'h0;
        step_reg <= avts_pkg::STEP_NOMINAL;
      end
    end
  end

  // ==========================================================================
  // sub-slot counter, slot index and rollover adjustment
  logic [11:0] roll_limit;
  logic roll_now;
  logic [4:0] slot_inc;
  logic [5:0] macro_len;

  always_comb begin
    roll_limit = avts_pkg::ROLL_NOMINAL;
    if (slot_left_reg != 4'h0) begin
      case (roll_sel_reg)
        avts_pkg::ROLL_SEL_LONG: roll_limit = avts_pkg::ROLL_LONG;
        avts_pkg::ROLL_SEL_SHORT: roll_limit = avts_pkg::ROLL_SHORT;
        default: roll_limit = avts_pkg::ROLL_NOMINAL; // reserved code runs nominal
      endcase
    end
  end

  assign roll_now = tick_en && (tick_cnt_reg >= roll_limit);
  assign slot_inc = slot_idx_reg + 5'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 12'h0;
      slot_idx_reg <= 5'h0;
    end else if (wr_go && idx == avts_pkg::IDX_SLOT_TICK) begin
      tick_cnt_reg <= pwdata[avts_pkg::TICK_CNT_LSB +: avts_pkg::TICK_CNT_W];
      slot_idx_reg <= pwdata[avts_pkg::SLOT_IDX_LSB +: avts_pkg::SLOT_IDX_W];
    end else if (roll_now) begin
      tick_cnt_reg <= 12'h1;
      slot_idx_reg <= slot_inc;
    end else if (tick_en) begin
      tick_cnt_reg <= tick_cnt_reg + 12'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      roll_sel_reg <= avts_pkg::ROLL_SEL_NOM;
      slot_left_reg <= 4'h0;
      macro_sel_reg <= avts_pkg::MACRO_SEL_1MS;
    end else if (wr_go && idx == avts_pkg::IDX_ROLL_ADJUST) begin
      roll_sel_reg <= pwdata[avts_pkg::ROLL_SEL_LSB +: avts_pkg::SEL_W];
      slot_left_reg <= pwdata[avts_pkg::SLOT_PERIOD_LSB +: avts_pkg::PERIOD_W];
      macro_sel_reg <= pwdata[avts_pkg::MACRO_SEL_LSB +: avts_pkg::SEL_W];
    end else if (roll_now) begin
      if (slot_left_reg > 4'h1) begin
        slot_left_reg <= slot_left_reg - 4'h1;
      end else begin
        slot_left_reg <= 4'h0;
        roll_sel_reg <= avts_pkg::ROLL_SEL_NOM;
      end
    end
  end

  // macro length in slots; the 5-bit slot index wraps every 4 ms
  always_comb begin
    case (macro_sel_reg)
      avts_pkg::MACRO_SEL_2MS: macro_len = avts_pkg::MACRO_SLOTS_2MS;
      avts_pkg::MACRO_SEL_4MS: macro_len = avts_pkg::MACRO_SLOTS_4MS;
      default: macro_len = avts_pkg::MACRO_SLOTS_1MS;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_pulse <= 1'b0;
      macro_slot_pulse <= 1'b0;
    end else begin
      slot_pulse <= roll_now;
      macro_slot_pulse <= roll_now && ((slot_inc & (macro_len[4:0] - 5'h1)) == 5'h0);
    end
  end

  // ==========================================================================
  // frame classification, length checks, timestamps and report request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_queue4 <= 1'b0;
      to_queue5 <= 1'b0;
      ingress_len_ok <= 1'b0;
      egress_gate_open <= 1'b0;
    end else begin
      // class a wins if both codes are programmed alike
      to_queue5 <= ingress_frame_valid && ingress_tagged
        && ingress_priority_code == class_a_reg;
      to_queue4 <= ingress_frame_valid && ingress_tagged
        && ingress_priority_code == class_b_reg && ingress_priority_code != class_a_reg;
      ingress_len_ok <= ingress_frame_valid && ingress_frame_len <= {2'h0, max_len_reg};
      egress_gate_open <= egress_frame_len <= {2'h0, max_len_reg};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ingress_timestamp <= 32'h0;
      egress_timestamp <= 32'h0;
      report_frame_req <= 1'b0;
    end else begin
      if (ingress_sync_rx) begin
        ingress_timestamp <= time_base_reg;
      end
      if (egress_sync_tx) begin
        egress_timestamp <= time_base_reg;
      end
      report_frame_req <= egress_sync_tx && report_en_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_base <= 32'h0;
      slot_index <= 5'h0;
    end else begin
      time_base <= time_base_reg;
      slot_index <= slot_idx_reg;
    end
  end

  // ==========================================================================
  // checks
  a_report_on: assert property (@(posedge pclk) disable iff (!presetn)
    egress_sync_tx && report_en_reg |=> report_frame_req)
    else $error("report request missing");
  a_report_off: assert property (@(posedge pclk) disable iff (!presetn)
    report_frame_req |-> $past(egress_sync_tx) && $past(report_en_reg))
    else $error("report request without cause");
  a_queue4_map: assert property (@(posedge pclk) disable iff (!presetn)
    to_queue4 |-> $past(ingress_priority_code) == $past(class_b_reg))
    else $error("queue 4 code mismatch");
  a_queue5_map: assert property (@(posedge pclk) disable iff (!presetn)
    ingress_frame_valid && ingress_tagged && ingress_priority_code == class_a_reg |=> to_queue5)
    else $error("class a frame not sent to queue 5");
  a_ingress_len: assert property (@(posedge pclk) disable iff (!presetn)
    ingress_frame_valid && ingress_frame_len > {2'h0, max_len_reg} |=> !ingress_len_ok)
    else $error("oversize frame passed");
  a_egress_gate: assert property (@(posedge pclk) disable iff (!presetn)
    egress_gate_open |-> $past(egress_frame_len) <= {2'h0, $past(max_len_reg)})
    else $error("egress gate open for oversize frame");
  a_time_step: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en |=> time_base_reg == $past(time_base_reg) + {26'h0, $past(eff_step)})
    else $error("time base did not advance by step");
  a_time_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !tick_en |=> $stable(time_base_reg))
    else $error("time base moved without tick");
  a_egress_stamp: assert property (@(posedge pclk) disable iff (!presetn)
    egress_sync_tx |=> egress_timestamp == $past(time_base_reg))
    else $error("egress timestamp wrong");
  a_slot_roll: assert property (@(posedge pclk) disable iff (!presetn)
    roll_now && !wr_go |=> tick_cnt_reg == 12'h1 && slot_idx_reg == $past(slot_inc) && slot_pulse)
    else $error("slot rollover wrong");
  a_step_expire: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en && step_left_reg == 4'h1 && !wr_go |=> step_reg == avts_pkg::STEP_NOMINAL)
    else $error("step did not return to nominal");

endmodule : avts_slot_timer

// ==== verilog/avts_tick_div.sv ====
/*
  divider that turns the 200 MHz bus clock into a one-cycle 25 MHz tick enable.
  assumes pclk and presetn are those of the slot timer.
*/
`timescale 1ns/1ps
module avts_tick_div (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // tick enable, one cycle in every TICK_DIV
  output logic tick_en
);

  // ==========================================================================
  // divider
  logic [3:0] div_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 4'h0;
      tick_en <= 1'b0;
    end else if (div_reg == 4'(avts_pkg::TICK_DIV - 1)) begin
      div_reg <= 4'h0;
      tick_en <= 1'b1;
    end else begin
      div_reg <= div_reg + 4'h1;
      tick_en <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick_en |=> !tick_en [*7] ##1 tick_en)
    else $error("tick enable not spaced by eight cycles");

endmodule : avts_tick_div
